// ===== hdl/ioc_sys_pkg.sv
`default_nettype none
package ioc_sys_pkg;
  // ****************************************
  // command codes (low five bits)
  // ****************************************
  localparam logic [4:0] SOFT_RESET_CMD = 5'h00;
  localparam logic [4:0] ERROR_RESET_CMD = 5'h01;
  localparam logic [4:0] SYSTEM_STATUS_CMD = 5'h02;
  localparam logic [4:0] DEVICE_STATUS_CMD = 5'h03;
  localparam logic [4:0] MASKED_IRQ_ACK_CMD = 5'h04;
  localparam logic [4:0] IRQ_ACK_ALL_CMD = 5'h05;
  localparam logic [4:0] IRQ_TEST_CMD = 5'h06;
  localparam logic [4:0] ECHO_TEST_CMD = 5'h07;
  localparam logic [4:0] ROM_CHECKSUM_CMD = 5'h08;
  localparam logic [4:0] RAM_SELF_TEST_CMD = 5'h09;
  localparam logic [4:0] IRQ_ENABLE_CMD = 5'h0a;
  localparam logic [4:0] RSVD_LO_FIRST = 5'h0b;
  localparam logic [4:0] RSVD_LO_LAST = 5'h0f;
  localparam logic [4:0] RSVD_HI_FIRST = 5'h1d;
  localparam logic [4:0] RSVD_HI_LAST = 5'h1f;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_CODE_MSB = 4;
  localparam int CMD_IRQ_REQ_BIT = 7;
  localparam int SYS_ILL_MASK_BIT = 0;
  localparam int SYS_ILL_DATA_BIT = 1;
  localparam int SYS_ILL_CMD_BIT = 2;
  localparam int SYS_DEV_ERR_BIT = 3;
  localparam int DEV_IRQ_LSB = 0;
  localparam int DEV_ERR_LSB = 4;
  localparam int NUM_DEV = 4;
  // ****************************************
  // reset values and result bytes
  // ****************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int SOFT_RESET_MS = 100;
  localparam int ECHO_MS = 2;
  localparam int ROM_TEST_MS = 100;
  localparam int RAM_TEST_MS = 100;
  localparam int SOFT_RESET_CYC = SOFT_RESET_MS * (CLK_HZ / 1000);
  localparam int ECHO_CYC = ECHO_MS * (CLK_HZ / 1000);
  localparam int ROM_TEST_CYC = ROM_TEST_MS * (CLK_HZ / 1000);
  localparam int RAM_TEST_CYC = RAM_TEST_MS * (CLK_HZ / 1000);
  localparam int RAM_DEPTH = 16;
  localparam int ROM_DEPTH = 16;
  localparam int TIMER_W = 24;
endpackage
`default_nettype wire

// ===== hdl/rom_sum_check.sv
`default_nettype none
module rom_sum_check #(
  parameter int DEPTH = ioc_sys_pkg::ROM_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o,
  output logic fail_o
);
  import ioc_sys_pkg::*;
  // ****************************************
  // constant image with a trailing balance byte
  // ****************************************
  function automatic logic [7:0] rom_byte(input logic [7:0] idx);
    // balance byte cancels the sum of all the bytes below it
    rom_byte = (idx == 8'(DEPTH - 1)) ? 8'(0 - 8'h11 * ((DEPTH - 1) * (DEPTH - 2) / 2)) :
      idx * 8'h11;
  endfunction
  logic [7:0] idx_reg;
  logic [7:0] sum_reg;
  logic run_reg;
  wire logic last = (idx_reg == 8'(DEPTH - 1));
  wire logic [7:0] sum_next = sum_reg + rom_byte(idx_reg);
  // walk once over the image; sum must come back to zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_reg <= 8'h00;
      sum_reg <= 8'h00;
      run_reg <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        idx_reg <= 8'h00;
        sum_reg <= 8'h00;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        idx_reg <= idx_reg + 8'h01;
        sum_reg <= sum_next;
        if (last) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
          fail_o <= (sum_next != 8'h00);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ram_self_test.sv
`default_nettype none
module ram_self_test #(
  parameter int DEPTH = ioc_sys_pkg::RAM_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o,
  output logic fail_o
);
  import ioc_sys_pkg::*;
  // ****************************************
  // flip-flop scratch store, write then read back
  // ****************************************
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] idx_reg;
  logic rd_phase_reg;
  logic run_reg;
  wire logic [7:0] pattern = idx_reg ^ 8'h5a;
  wire logic bad = (mem_reg[idx_reg[3:0]] != pattern);
  // storage has no reset; it is written before any read
  always_ff @(posedge clk_sys_i) begin
    if (run_reg && !rd_phase_reg) begin
      mem_reg[idx_reg[3:0]] <= pattern;
    end
  end
  // stop at the first location that reads back wrong
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_reg <= 8'h00;
      rd_phase_reg <= 1'b0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        idx_reg <= 8'h00;
        rd_phase_reg <= 1'b0;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        idx_reg <= idx_reg + 8'h01;
        if (rd_phase_reg && bad) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
          fail_o <= 1'b1;
        end else if (idx_reg == 8'(DEPTH - 1)) begin
          idx_reg <= 8'h00;
          rd_phase_reg <= 1'b1;
          if (rd_phase_reg) begin
            run_reg <= 1'b0;
            done_o <= 1'b1;
            fail_o <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/io_controller_system_commands.sv
// Contract
// - soft reset command, taken only when idle, drops any unread output byte and reinitialises state, no data byte.
// - error reset command does nothing.
// - bit 7 ignored for system commands; no interrupt on completion.
// - system status command loads system status byte, output full, flag 0.
// - device status command loads device status byte, output full, flag 0.
// - mask naming a clear interrupt bit sets illegal-mask; clears on status read.
// - data byte without command is dropped and sets illegal-data bit.
// - reserved codes not executed; set illegal-command bit, cleared on read.
// - device timeout sets summary device error; device status command clears it.
// - device done with interrupt enabled sets its interrupt bit.
// - device timeout sets its error bit; cleared on device status read.
// - masked ack takes one mask byte, clears masked bits and interrupt line.
// - ack-all clears all interrupt bits and the interrupt line.
// - interrupt test raises the line until ack-all.
// - echo returns complement of next data byte after about 2 ms.
// - enable byte persistently enables device interrupts and the line.
// - rom checksum: zeros flag 0 on pass, ones flag 1 on fail.
// - ram test stops at first fault: ones flag 1 fail, zeros flag 0 pass.
// - busy set on accepting a command that leaves idle, cleared when processing ends.
// - output full sets on buffer write, clears on master data read.
// - command/data flag 0 for status and requested data bytes, 1 only for a self-test fail byte.
`default_nettype none
module io_controller_system_commands #(
  parameter int SOFT_RESET_CYCLES = ioc_sys_pkg::SOFT_RESET_CYC,
  parameter int ECHO_CYCLES = ioc_sys_pkg::ECHO_CYC,
  parameter int ROM_TEST_CYCLES = ioc_sys_pkg::ROM_TEST_CYC,
  parameter int RAM_TEST_CYCLES = ioc_sys_pkg::RAM_TEST_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic host_wr_i,
  input wire logic host_cmd_sel_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_data_rd_i,
  input wire logic [ioc_sys_pkg::NUM_DEV-1:0] dev_done_i,
  input wire logic [ioc_sys_pkg::NUM_DEV-1:0] dev_timeout_i,
  input wire logic [ioc_sys_pkg::NUM_DEV-1:0] dev_irq_req_i,
  output logic [7:0] host_rdata_o,
  output logic [7:0] host_status_o,
  output logic irq_o
);
  import ioc_sys_pkg::*;

  // ****************************************
  // state and storage
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_BYTE = 3'b001,
    ST_TIMED = 3'b010,
    ST_SELFTEST = 3'b011
  } ctl_state_e;

  ctl_state_e state_reg, state_next;
  logic [4:0] cmd_reg;
  logic [7:0] in_byte_reg;
  logic input_full_flag;
  logic in_cd_reg;
  logic [7:0] out_byte_reg;
  logic output_full_flag;
  logic out_cd_reg;
  logic busy_flag;
  logic [7:0] system_status_byte;
  logic [7:0] device_status_byte;
  logic [NUM_DEV-1:0] irq_enable_reg;
  logic irq_line_reg;
  logic irq_test_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [7:0] echo_reg;
  logic selftest_rom_reg;
  logic rom_go_reg, ram_go_reg;
  logic st_seen_reg;
  logic rom_done, rom_fail, ram_done, ram_fail;

  // classify a command code
  function automatic logic is_reserved(input logic [4:0] c);
    is_reserved = (c >= RSVD_LO_FIRST && c <= RSVD_LO_LAST) ||
                  (c >= RSVD_HI_FIRST && c <= RSVD_HI_LAST);
  endfunction
  function automatic logic [TIMER_W-1:0] cyc(input int n);
    cyc = TIMER_W'(n);
  endfunction

  // ****************************************
  // decoding
  // ****************************************
  // host strobes land in the input buffer; commands are consumed in idle, data bytes in any state
  wire logic [4:0] new_code = in_byte_reg[CMD_CODE_MSB:0];
  wire logic take_cmd = input_full_flag && in_cd_reg && state_reg == ST_IDLE;
  wire logic take_data = input_full_flag && !in_cd_reg && state_reg == ST_WAIT_BYTE;
  wire logic stray_data = input_full_flag && !in_cd_reg && state_reg != ST_WAIT_BYTE;
  wire logic consume = take_cmd || take_data || stray_data;
  wire logic code_rsvd = take_cmd && is_reserved(new_code);
  wire logic do_soft_reset = take_cmd && new_code == SOFT_RESET_CMD;
  wire logic do_sys_stat = take_cmd && new_code == SYSTEM_STATUS_CMD;
  wire logic do_dev_stat = take_cmd && new_code == DEVICE_STATUS_CMD;
  wire logic do_ack_all = take_cmd && new_code == IRQ_ACK_ALL_CMD;
  wire logic do_irq_test = take_cmd && new_code == IRQ_TEST_CMD;
  wire logic needs_byte = take_cmd && (new_code == MASKED_IRQ_ACK_CMD ||
                          new_code == ECHO_TEST_CMD || new_code == IRQ_ENABLE_CMD);
  wire logic do_selftest = take_cmd && (new_code == ROM_CHECKSUM_CMD ||
                           new_code == RAM_SELF_TEST_CMD);
  wire logic mask_byte = take_data && cmd_reg == MASKED_IRQ_ACK_CMD;
  wire logic en_byte = take_data && cmd_reg == IRQ_ENABLE_CMD;
  wire logic echo_byte = take_data && cmd_reg == ECHO_TEST_CMD;
  wire logic [NUM_DEV-1:0] cur_irq = device_status_byte[DEV_IRQ_LSB +: NUM_DEV];
  wire logic [NUM_DEV-1:0] mask_bits = in_byte_reg[NUM_DEV-1:0];
  wire logic bad_mask = mask_byte && |(mask_bits & ~cur_irq);
  wire logic timer_zero = (timer_reg == '0);
  wire logic st_done = selftest_rom_reg ? rom_done : ram_done;
  wire logic st_fail = selftest_rom_reg ? rom_fail : ram_fail;
  // engines pulse done once; it is held until the minimum run time is over
  wire logic st_finish = (st_done || st_seen_reg) && timer_zero;
  // status bytes go out with the command/data flag clear
  wire logic sys_read = host_data_rd_i && output_full_flag && !out_cd_reg &&
                        cmd_reg == SYSTEM_STATUS_CMD;
  wire logic dev_read = host_data_rd_i && output_full_flag && !out_cd_reg &&
                        cmd_reg == DEVICE_STATUS_CMD;
  // device events: bit 7 of the device's own command or a persistent enable
  wire logic [NUM_DEV-1:0] irq_set = dev_done_i & (dev_irq_req_i | irq_enable_reg);

  // ****************************************
  // controller state walk
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (do_soft_reset || echo_byte) state_next = ST_TIMED;
        else if (needs_byte) state_next = ST_WAIT_BYTE;
        else if (do_selftest) state_next = ST_SELFTEST;
      end
      ST_WAIT_BYTE: begin
        if (echo_byte) state_next = ST_TIMED;
        else if (take_data) state_next = ST_IDLE;
      end
      ST_TIMED: begin
        if (timer_zero) state_next = ST_IDLE;
      end
      ST_SELFTEST: begin
        if (st_finish) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ****************************************
  // host buffer: input side
  // ****************************************
  // a write while full overwrites; the master is expected to poll first
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_byte_reg <= BYTE_ZERO;
      input_full_flag <= 1'b0;
      in_cd_reg <= 1'b0;
    end else if (host_wr_i) begin
      in_byte_reg <= host_wdata_i;
      input_full_flag <= 1'b1;
      in_cd_reg <= host_cmd_sel_i;
    end else if (consume) begin
      input_full_flag <= 1'b0;
    end
  end

  // ****************************************
  // sequencing, timer, busy
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cmd_reg <= SOFT_RESET_CMD;
      timer_reg <= '0;
      busy_flag <= 1'b0;
      echo_reg <= BYTE_ZERO;
      selftest_rom_reg <= 1'b0;
      rom_go_reg <= 1'b0;
      ram_go_reg <= 1'b0;
      st_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take_cmd) st_seen_reg <= 1'b0;
      else if (st_done) st_seen_reg <= 1'b1;
      rom_go_reg <= do_selftest && new_code == ROM_CHECKSUM_CMD;
      ram_go_reg <= do_selftest && new_code == RAM_SELF_TEST_CMD;
      if (take_cmd) cmd_reg <= new_code;
      if (take_cmd) selftest_rom_reg <= (new_code == ROM_CHECKSUM_CMD);
      if (echo_byte) echo_reg <= ~in_byte_reg;
      // minimum run times model the documented firmware durations
      if (do_soft_reset) timer_reg <= cyc(SOFT_RESET_CYCLES - 1);
      else if (echo_byte) timer_reg <= cyc(ECHO_CYCLES - 1);
      else if (do_selftest && new_code == ROM_CHECKSUM_CMD) timer_reg <= cyc(ROM_TEST_CYCLES - 1);
      else if (do_selftest) timer_reg <= cyc(RAM_TEST_CYCLES - 1);
      else if (!timer_zero) timer_reg <= timer_reg - 1'b1;
      // busy from the accepting edge until the state returns idle
      busy_flag <= (state_next != ST_IDLE);
    end
  end

  // ****************************************
  // host buffer: output side
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_byte_reg <= BYTE_ZERO;
      output_full_flag <= 1'b0;
      out_cd_reg <= 1'b0;
    end else if (do_soft_reset) begin
      output_full_flag <= 1'b0;
    end else if (do_sys_stat) begin
      out_byte_reg <= system_status_byte;
      output_full_flag <= 1'b1;
      out_cd_reg <= 1'b0;
    end else if (do_dev_stat) begin
      out_byte_reg <= device_status_byte;
      output_full_flag <= 1'b1;
      out_cd_reg <= 1'b0;
    end else if (state_reg == ST_TIMED && timer_zero && cmd_reg == ECHO_TEST_CMD) begin
      out_byte_reg <= echo_reg;
      output_full_flag <= 1'b1;
      out_cd_reg <= 1'b0;
    end else if (state_reg == ST_SELFTEST && st_finish) begin
      out_byte_reg <= st_fail ? BYTE_ONES : BYTE_ZERO;
      output_full_flag <= 1'b1;
      out_cd_reg <= st_fail;
    end else if (host_data_rd_i) begin
      output_full_flag <= 1'b0;
    end
  end

  // ****************************************
  // status bytes and interrupts
  // ****************************************
  // event sets win over read clears in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_status_byte <= BYTE_ZERO;
      device_status_byte <= BYTE_ZERO;
      irq_enable_reg <= NIBBLE_ZERO;
      irq_line_reg <= 1'b0;
      irq_test_reg <= 1'b0;
    end else if (do_soft_reset) begin
      system_status_byte <= BYTE_ZERO;
      device_status_byte <= BYTE_ZERO;
      irq_enable_reg <= NIBBLE_ZERO;
      irq_line_reg <= 1'b0;
      irq_test_reg <= 1'b0;
    end else begin
      system_status_byte[SYS_ILL_MASK_BIT] <= bad_mask ||
        (system_status_byte[SYS_ILL_MASK_BIT] && !sys_read);
      system_status_byte[SYS_ILL_DATA_BIT] <= stray_data ||
        (system_status_byte[SYS_ILL_DATA_BIT] && !sys_read);
      system_status_byte[SYS_ILL_CMD_BIT] <= code_rsvd ||
        (system_status_byte[SYS_ILL_CMD_BIT] && !sys_read);
      system_status_byte[SYS_DEV_ERR_BIT] <= |dev_timeout_i ||
        (system_status_byte[SYS_DEV_ERR_BIT] && !do_dev_stat);
      device_status_byte[DEV_ERR_LSB +: NUM_DEV] <= dev_timeout_i |
        (device_status_byte[DEV_ERR_LSB +: NUM_DEV] & {NUM_DEV{!dev_read}});
      // error reset and bit 7 of a system command touch nothing here
      if (do_ack_all) begin
        device_status_byte[DEV_IRQ_LSB +: NUM_DEV] <= irq_set;
      end else if (mask_byte) begin
        device_status_byte[DEV_IRQ_LSB +: NUM_DEV] <= irq_set | (cur_irq & ~mask_bits);
      end else begin
        device_status_byte[DEV_IRQ_LSB +: NUM_DEV] <= irq_set | cur_irq;
      end
      if (en_byte) irq_enable_reg <= in_byte_reg[NUM_DEV-1:0];
      if (do_irq_test) irq_test_reg <= 1'b1;
      else if (do_ack_all) irq_test_reg <= 1'b0;
      // line follows new device events; acks drop it; system commands never raise it
      if (|irq_set) irq_line_reg <= 1'b1;
      else if (do_ack_all || mask_byte) irq_line_reg <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_rdata_o <= BYTE_ZERO;
      host_status_o <= BYTE_ZERO;
      irq_o <= 1'b0;
    end else begin
      host_rdata_o <= out_byte_reg;
      host_status_o <= {4'h0, out_cd_reg, busy_flag, input_full_flag, output_full_flag};
      irq_o <= irq_line_reg || irq_test_reg;
    end
  end

  // ****************************************
  // self-test engines
  // ****************************************
  rom_sum_check #(.DEPTH(ROM_DEPTH)) u_rom (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(rom_go_reg),
    .done_o(rom_done),
    .fail_o(rom_fail)
  );
  ram_self_test #(.DEPTH(RAM_DEPTH)) u_ram (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(ram_go_reg),
    .done_o(ram_done),
    .fail_o(ram_fail)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_rsvd_taken;
    code_rsvd;
  endsequence
  a_rsvd_sets_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_rsvd_taken |=> system_status_byte[SYS_ILL_CMD_BIT]) else $error("reserved code");
  a_stray_data_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    stray_data |=> system_status_byte[SYS_ILL_DATA_BIT] && !input_full_flag)
    else $error("stray data not flagged");
  a_sys_stat_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_sys_stat |=> output_full_flag && !out_cd_reg ##1 host_status_o[0])
    else $error("system status not loaded");
  a_dev_stat_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_dev_stat |=> out_byte_reg == $past(device_status_byte)) else $error("dev status");
  a_ack_all_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_ack_all && !(|irq_set) |=> cur_irq == '0 && !irq_test_reg) else $error("ack all");
  a_irq_test_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_irq_test |=> irq_test_reg ##1 irq_o) else $error("irq test");
  a_busy_on_accept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    take_cmd && state_next != ST_IDLE |=> busy_flag) else $error("busy not set");
  a_dev_err_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_dev_stat && !(|dev_timeout_i) |=> !system_status_byte[SYS_DEV_ERR_BIT])
    else $error("device error kept");
  a_echo_complement: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    echo_byte |=> echo_reg == ~$past(in_byte_reg)) else $error("echo wrong");
  a_bad_mask_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bad_mask |=> system_status_byte[SYS_ILL_MASK_BIT]) else $error("illegal mask not flagged");
  a_read_clears_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sys_read |=> !output_full_flag) else $error("output full kept after read");
endmodule
`default_nettype wire

// ===== test/host_master_model.sv
`default_nettype none
module host_master_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] host_status_i,
  input wire logic [7:0] host_rdata_i,
  output logic host_wr_o,
  output logic host_cmd_sel_o,
  output logic [7:0] host_wdata_o,
  output logic host_data_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // polled master
  // ****************
  initial begin
    host_wr_o = 1'b0;
    host_cmd_sel_o = 1'b0;
    host_wdata_o = 8'h00;
    host_data_rd_o = 1'b0;
  end
  // bounded poll: input full clear before any write, busy clear before a command
  task automatic idle_wait(input logic sel, output bit ok);
    ok = 1'b0;
    repeat (5000) begin
      @(posedge clk_sys_i);
      if ((!sel || host_status_i[2] === 1'b0) && host_status_i[1] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask
  // released data lines show the inverse, never a stale byte
  task automatic put_byte(input logic sel, input logic [7:0] b, output bit ok);
    idle_wait(sel, ok);
    if (ok) begin
      #1 host_wr_o = 1'b1;
      host_cmd_sel_o = sel;
      host_wdata_o = b;
      @(posedge clk_sys_i);
      #1 host_wr_o = 1'b0;
      host_wdata_o = ~b;
      repeat (3) @(posedge clk_sys_i);
      #1;
    end
  endtask
  // take byte and flag at the edge that shows output full, then read it
  task automatic get_byte(output logic [7:0] b, output logic cd, output bit ok);
    ok = 1'b0;
    repeat (5000) begin
      @(posedge clk_sys_i);
      if (host_status_i[0] === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    b = host_rdata_i;
    cd = host_status_i[3];
    if (ok) begin
      #1 host_data_rd_o = 1'b1;
      @(posedge clk_sys_i);
      #1 host_data_rd_o = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/io_controller_system_commands_tb.sv
`default_nettype none
module io_controller_system_commands_tb;
  import ioc_sys_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rst_n_i, host_wr_i, host_cmd_sel_i, host_data_rd_i, irq_o, cd;
  logic [7:0] host_wdata_i, host_rdata_o, host_status_o, rb;
  logic [NUM_DEV-1:0] dev_done_i, dev_timeout_i, dev_irq_req_i;
  logic [7:0] rsv [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1d, 8'h1e, 8'h1f};
  int error_cnt = 0;
  int compares = 0;
  bit ok;
  // ****************
  // harness
  // ****************
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // short counts keep the run brief
  io_controller_system_commands #(.SOFT_RESET_CYCLES(20), .ECHO_CYCLES(20),
    .ROM_TEST_CYCLES(20), .RAM_TEST_CYCLES(20)) dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .host_wr_i(host_wr_i), .host_cmd_sel_i(host_cmd_sel_i),
    .host_wdata_i(host_wdata_i), .host_data_rd_i(host_data_rd_i),
    .dev_done_i(dev_done_i), .dev_timeout_i(dev_timeout_i), .dev_irq_req_i(dev_irq_req_i),
    .host_rdata_o(host_rdata_o), .host_status_o(host_status_o), .irq_o(irq_o));
  host_master_model m (.clk_sys_i(clk_sys_i), .host_status_i(host_status_o),
    .host_rdata_i(host_rdata_o), .host_wr_o(host_wr_i), .host_cmd_sel_o(host_cmd_sel_i),
    .host_wdata_o(host_wdata_i), .host_data_rd_o(host_data_rd_i));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(string what, logic e, logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic hang_chk();
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED handshake expected ready seen timeout");
      end_sim();
    end
  endtask
  task automatic cmd(logic [7:0] b);
    m.put_byte(1'b1, b, ok);
    hang_chk();
  endtask
  task automatic dat(logic [7:0] b);
    m.put_byte(1'b0, b, ok);
    hang_chk();
  endtask
  // issue a status or test command and compare the returned byte and flag
  task automatic ask(logic [7:0] c, string what, logic [7:0] e, logic ecd);
    cmd(c);
    m.get_byte(rb, cd, ok);
    hang_chk();
    chk8(what, e, rb);
    chk1("cmd_data_flag", ecd, cd);
  endtask
  // one-cycle event pulse from a device
  task automatic dev_pulse(logic tmo, logic [3:0] v);
    @(posedge clk_sys_i);
    #1 if (tmo) dev_timeout_i = v;
    else dev_done_i = v;
    @(posedge clk_sys_i);
    #1 dev_done_i = '0;
    dev_timeout_i = '0;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    rst_n_i = 1'b0;
    dev_done_i = '0;
    dev_timeout_i = '0;
    dev_irq_req_i = '0;
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    ask(8'h82, "sys_status", 8'h00, 1'b0);
    chk1("out_full", 1'b0, host_status_o[0]);
    foreach (rsv[i]) cmd(rsv[i]);
    ask(8'h02, "sys_status", 8'h04, 1'b0);
    ask(8'h02, "sys_status", 8'h00, 1'b0);
    dat(8'h5a);
    ask(8'h02, "sys_status", 8'h02, 1'b0);
    cmd(8'h04);
    dat(8'h01);
    ask(8'h02, "sys_status", 8'h01, 1'b0);
    $display("test errors done");
    cmd(8'h87);
    dat(8'ha5);
    m.get_byte(rb, cd, ok);
    hang_chk();
    chk8("echo", 8'h5a, rb);
    chk1("irq", 1'b0, irq_o);
    ask(8'h08, "rom_check", 8'h00, 1'b0);
    ask(8'h09, "ram_check", 8'h00, 1'b0);
    cmd(8'h01);
    ask(8'h02, "sys_status", 8'h00, 1'b0);
    $display("test diagnostics done");
    cmd(8'h06);
    chk1("irq", 1'b1, irq_o);
    ask(8'h03, "dev_status", 8'h00, 1'b0);
    cmd(8'h05);
    chk1("irq", 1'b0, irq_o);
    cmd(8'h0a);
    dat(8'h01);
    dev_pulse(1'b0, 4'h1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk1("irq", 1'b1, irq_o);
    ask(8'h03, "dev_status", 8'h01, 1'b0);
    cmd(8'h04);
    dat(8'h01);
    chk1("irq", 1'b0, irq_o);
    ask(8'h03, "dev_status", 8'h00, 1'b0);
    dev_irq_req_i = 4'h4;
    dev_pulse(1'b0, 4'h4);
    dev_pulse(1'b0, 4'h8);
    ask(8'h03, "dev_status", 8'h04, 1'b0);
    cmd(8'h05);
    chk1("irq", 1'b0, irq_o);
    $display("test interrupts done");
    dev_pulse(1'b1, 4'h2);
    ask(8'h02, "sys_status", 8'h08, 1'b0);
    ask(8'h03, "dev_status", 8'h20, 1'b0);
    ask(8'h02, "sys_status", 8'h00, 1'b0);
    ask(8'h03, "dev_status", 8'h00, 1'b0);
    $display("test device errors done");
    dat(8'h33);
    cmd(8'h00);
    chk1("busy", 1'b1, host_status_o[2]);
    ask(8'h02, "sys_status", 8'h00, 1'b0);
    $display("test soft reset done");
    end_sim();
  end
endmodule
`default_nettype wire
